// file: rtl/plc_top.sv
// loop lock and multiplier control: register file over axi4-lite, lock status, change flag, clock gating
// assumes: lock and tracking detectors and both clock inputs are asynchronous to aclk;
// stop_request and break_active come from system logic on aclk
`timescale 1ns/1ps

module plc_top
    import plc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int SYNC_INPUTS = 4
)(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_WIDTH-1:0] awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // axi4-lite write response
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // axi4-lite read
    input  wire logic [ADDR_WIDTH-1:0] araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // analog loop and oscillator side, asynchronous
    input  wire logic                  lock_detect,
    input  wire logic                  track_detect,
    input  wire logic                  crystal_clock,
    input  wire logic                  vco_clock,
    // system state
    input  wire logic                  stop_request,
    input  wire logic                  break_active,
    // controls to the analog loop
    output logic                       osc_enable,
    output logic                       vco_clock_enable,
    output logic                       loop_track_mode,
    output logic [11:0]                feedback_divider,
    output logic [7:0]                 vco_range_factor,
    output logic [1:0]                 vco_power_range,
    // clock and interrupt outputs
    output logic                       crystal_clock_out,
    output logic                       base_clock_out,
    output logic                       clock_gen_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decoding shared by read and write

    function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
        reg_index = addr[9:2];
    endfunction : reg_index

    function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        is_mapped = (addr[1:0] == 2'h0) && (addr[ADDR_WIDTH-1:10] == '0) &&
                    ((idx == PLC_IDX_LOOP_CTRL) || (idx == PLC_IDX_BW_MODE) ||
                     (idx == PLC_IDX_MUL_LOW) || (idx == PLC_IDX_MUL_HIGH) ||
                     (idx == PLC_IDX_VCO_RANGE) || (idx == PLC_IDX_SYS_CTRL));
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [ADDR_WIDTH-1:0] aw_addr;
    logic                  aw_held;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  w_held;
    plc_loop_ctrl_type     loop_ctrl;
    logic                  auto_mode;
    logic                  manual_track;
    logic                  lock_bit;
    logic                  lock_prev;
    logic [7:0]            mul_low;
    logic [3:0]            mul_high;
    logic [7:0]            range_factor;
    logic                  osc_run_in_stop;
    logic                  break_clear_enable;
    logic                  src_prev;
    logic [SYNC_INPUTS-1:0] sync1;
    logic [SYNC_INPUTS-1:0] sync2;
    logic [SYNC_INPUTS-1:0] sync3;
    logic [SYNC_INPUTS-1:0] filt;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, change accepted when stages two and three agree

    wire [SYNC_INPUTS-1:0] async_in = {vco_clock, crystal_clock, track_detect, lock_detect};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_INPUTS; gi++)
        begin : g_sync
            // sync chain with agreement filter
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi]  <= 1'b0;
                end
                else
                begin
                    sync1[gi] <= async_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    wire lock_filt  = filt[0];
    wire track_filt = filt[1];
    wire xclk_filt  = filt[2];
    wire vclk_filt  = filt[3];

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire        aw_take    = awvalid && awready;
    wire        w_take     = wvalid && wready;
    wire        ar_take    = arvalid && arready;
    wire        do_write   = aw_held && w_held && !bvalid;
    wire        wr_mapped  = is_mapped(aw_addr);
    wire [7:0]  wr_index   = reg_index(aw_addr);
    wire        wr_en      = do_write && wr_mapped && w_lane0;
    wire        wr_ctrl    = wr_en && (wr_index == PLC_IDX_LOOP_CTRL);
    wire        wr_bw      = wr_en && (wr_index == PLC_IDX_BW_MODE);
    wire        wr_low     = wr_en && (wr_index == PLC_IDX_MUL_LOW);
    wire        wr_high    = wr_en && (wr_index == PLC_IDX_MUL_HIGH);
    wire        wr_range   = wr_en && (wr_index == PLC_IDX_VCO_RANGE);
    wire        wr_sys     = wr_en && (wr_index == PLC_IDX_SYS_CTRL);
    wire        rd_mapped  = is_mapped(araddr);
    wire [7:0]  rd_index   = reg_index(araddr);
    wire        rd_ctrl    = ar_take && rd_mapped && (rd_index == PLC_IDX_LOOP_CTRL);

    ////////////////////////////////////////////////////////////////////////////////
    // loop status

    wire range_zero   = (range_factor == 8'h00);
    wire halt_all     = stop_request && !osc_run_in_stop;
    wire loop_running = loop_ctrl.power_on && !range_zero && !stop_request;
    wire osc_running  = !halt_all;
    // wait has no input here: the generator runs on untouched through it
    wire lock_hw      = lock_filt && loop_running;
    wire lock_change  = auto_mode && (lock_hw != lock_prev);
    wire flag_clear   = rd_ctrl && (!break_active || break_clear_enable);
    wire track_read   = auto_mode ? track_filt : manual_track;

    ////////////////////////////////////////////////////////////////////////////////
    // next register values

    wire [7:0] wb = w_byte;
    wire next_auto = wr_bw ? wb[PLC_BW_AUTO_BIT] : auto_mode;
    wire next_manual_track = (wr_bw && !auto_mode) ? wb[PLC_BW_TRACK_BIT] : manual_track;
    // lock position of the write byte is dropped on purpose
    wire next_lock_bit = auto_mode && lock_hw;
    wire next_flag = !auto_mode ? 1'b0 :
                     lock_change ? 1'b1 :
                     flag_clear ? 1'b0 : loop_ctrl.change_flag;
    wire next_irq_en = !auto_mode ? 1'b0 :
                       wr_ctrl ? wb[7] : loop_ctrl.irq_enable;
    // power cannot drop while the vco drives the base clock
    wire next_power = wr_ctrl ? (wb[5] || loop_ctrl.base_source) : loop_ctrl.power_on;
    // source may be set with the loop on, locked or not, never with a zero range
    wire next_bcs = range_zero ? 1'b0 :
                    wr_ctrl ? (wb[4] && loop_ctrl.power_on) : loop_ctrl.base_source;
    wire [1:0] next_vpr = (wr_ctrl && !loop_ctrl.power_on) ? wb[1:0] : loop_ctrl.power_range;
    wire [7:0] next_low = (wr_low && !loop_ctrl.power_on) ? wb : mul_low;
    wire [3:0] next_high = (wr_high && !loop_ctrl.power_on) ? wb[PLC_MUL_HIGH_BITS-1:0] : mul_high;
    wire [7:0] next_range = (wr_range && !loop_ctrl.power_on) ? wb : range_factor;
    wire [11:0] mul_full = {mul_high, mul_low};
    wire [11:0] next_divider = (mul_full == 12'h000) ? PLC_MUL_ONE : mul_full;

    ////////////////////////////////////////////////////////////////////////////////
    // read data selection

    wire [7:0] ctrl_read = {loop_ctrl.irq_enable, loop_ctrl.change_flag && auto_mode,
                            loop_ctrl.power_on, loop_ctrl.base_source, 2'h0, loop_ctrl.power_range};
    wire [7:0] bw_read = {auto_mode, lock_bit, track_read, 5'h00};
    wire [7:0] sys_read = {6'h00, break_clear_enable, osc_run_in_stop};
    wire [7:0] read_byte = (rd_index == PLC_IDX_LOOP_CTRL) ? ctrl_read :
                           (rd_index == PLC_IDX_BW_MODE)   ? bw_read :
                           (rd_index == PLC_IDX_MUL_LOW)   ? mul_low :
                           (rd_index == PLC_IDX_MUL_HIGH)  ? {4'h0, mul_high} :
                           (rd_index == PLC_IDX_VCO_RANGE) ? range_factor :
                           (rd_index == PLC_IDX_SYS_CTRL)  ? sys_read : 8'h00;
    wire [31:0] read_word = rd_mapped ? {24'h000000, read_byte} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // clock path: divide selected source by two on its rising edges

    wire src_level  = loop_ctrl.base_source ? (vclk_filt && loop_running) : (xclk_filt && osc_running);
    wire src_rise   = src_level && !src_prev;
    wire next_base  = halt_all ? 1'b0 : (src_rise ? !base_clock_out : base_clock_out);

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= PLC_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr <= awaddr;
                aw_held <= 1'b1;
                awready <= 1'b0;
            end
            if (w_take)
            begin
                w_byte  <= wdata[7:0];
                w_lane0 <= wstrb[0];
                w_held  <= 1'b1;
                wready  <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_mapped ? PLC_RESP_OKAY : PLC_RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= PLC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= read_word;
            rresp   <= rd_mapped ? PLC_RESP_OKAY : PLC_RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control and status registers

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            loop_ctrl          <= plc_loop_ctrl_type'(PLC_RST_LOOP_CTRL);
            auto_mode          <= 1'b0;
            manual_track       <= 1'b0;
            lock_bit           <= 1'b0;
            lock_prev          <= 1'b0;
            mul_low            <= PLC_RST_MUL_LOW;
            mul_high           <= PLC_RST_MUL_HIGH;
            range_factor       <= PLC_RST_VCO_RANGE;
            osc_run_in_stop    <= 1'b0;
            break_clear_enable <= 1'b0;
        end
        else
        begin
            loop_ctrl.irq_enable  <= next_irq_en;
            loop_ctrl.change_flag <= next_flag;
            loop_ctrl.power_on    <= next_power;
            loop_ctrl.base_source <= next_bcs;
            loop_ctrl.reserved    <= 2'h0;
            loop_ctrl.power_range <= next_vpr;
            auto_mode             <= next_auto;
            manual_track          <= next_manual_track;
            lock_bit              <= next_lock_bit;
            lock_prev             <= lock_hw;
            mul_low               <= next_low;
            mul_high              <= next_high;
            range_factor          <= next_range;
            if (wr_sys)
            begin
                osc_run_in_stop    <= wb[PLC_SYS_OSC_BIT];
                break_clear_enable <= wb[PLC_SYS_BREAK_CLEAR_ENABLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs to the loop and the clock tree

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_enable        <= 1'b0;
            vco_clock_enable  <= 1'b0;
            loop_track_mode   <= 1'b0;
            feedback_divider  <= 12'h000;
            vco_range_factor  <= 8'h00;
            vco_power_range   <= 2'h0;
            crystal_clock_out <= 1'b0;
            base_clock_out    <= 1'b0;
            src_prev          <= 1'b0;
            clock_gen_irq     <= 1'b0;
        end
        else
        begin
            osc_enable        <= osc_running;
            vco_clock_enable  <= loop_running;
            loop_track_mode   <= track_read;
            feedback_divider  <= next_divider;
            vco_range_factor  <= range_factor;
            vco_power_range   <= loop_ctrl.power_range;
            crystal_clock_out <= xclk_filt && osc_running;
            base_clock_out    <= next_base;
            src_prev          <= src_level;
            clock_gen_irq     <= !halt_all && auto_mode &&
                                 loop_ctrl.change_flag && loop_ctrl.irq_enable;
        end
    end

endmodule : plc_top

// file: rtl/plc_pkg.sv
// package of the loop lock and multiplier control block: register indexes, field positions, reset values
// assumes: registers are 8 bits wide, one per aligned 32-bit word at byte address four times the index
package plc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register indexes (byte address is four times the index)
    localparam logic [7:0] PLC_IDX_LOOP_CTRL = 8'h36;
    localparam logic [7:0] PLC_IDX_BW_MODE   = 8'h37;
    localparam logic [7:0] PLC_IDX_MUL_LOW   = 8'h38;
    localparam logic [7:0] PLC_IDX_MUL_HIGH  = 8'h39;
    localparam logic [7:0] PLC_IDX_VCO_RANGE = 8'h3a;
    localparam logic [7:0] PLC_IDX_SYS_CTRL  = 8'h3c;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PLC_BW_AUTO_BIT   = 7;
    localparam int PLC_BW_LOCK_BIT   = 6;
    localparam int PLC_BW_TRACK_BIT  = 5;
    localparam int PLC_SYS_OSC_BIT   = 0;
    localparam int PLC_SYS_BREAK_CLEAR_ENABLE_BIT  = 1;
    localparam int PLC_MUL_HIGH_BITS = 4;
    localparam int PLC_MUL_BITS      = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  PLC_RST_LOOP_CTRL = 8'h20;
    localparam logic [7:0]  PLC_RST_MUL_LOW   = 8'h40;
    localparam logic [3:0]  PLC_RST_MUL_HIGH  = 4'h0;
    localparam logic [7:0]  PLC_RST_VCO_RANGE = 8'h40;
    localparam logic [11:0] PLC_MUL_ONE       = 12'h001;

    ////////////////////////////////////////////////////////////////////////////////
    // bus answers
    localparam logic [1:0] PLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;

    // loop control register layout, msb first
    typedef struct packed {
        logic       irq_enable;
        logic       change_flag;
        logic       power_on;
        logic       base_source;
        logic [1:0] reserved;
        logic [1:0] power_range;
    } plc_loop_ctrl_type;

endpackage : plc_pkg

// file: bench/plc_properties.sv
// concurrent checks of the loop control block: stop gating, divider, range, bus answers
// assumes: bound to plc_top, one clock domain aclk with synchronous active-low aresetn
`timescale 1ns/1ps

module plc_properties
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    // system state and outputs
    input wire logic        stop_request,
    input wire logic        osc_enable,
    input wire logic        vco_clock_enable,
    input wire logic [11:0] feedback_divider,
    input wire logic [7:0]  vco_range_factor,
    input wire logic        crystal_clock_out,
    input wire logic        base_clock_out,
    input wire logic        clock_gen_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // all checks share one clock and reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // osc_enable and the gated outputs are launched by the same edge, so they are compared in the same cycle
    a_full_stop_low: assert property (stop_request && !osc_enable |-> !crystal_clock_out && !base_clock_out && !clock_gen_irq)
        else $error("clock or irq output not low in full stop");
    a_osc_stop_only: assert property ($past(aresetn) && !osc_enable |-> $past(stop_request))
        else $error("oscillator off without stop");
    a_vco_off_stop: assert property (stop_request |=> !vco_clock_enable)
        else $error("loop still enabled in stop");
    a_div_never_zero: assert property ($past(aresetn) |-> feedback_divider != 12'h000)
        else $error("feedback divider zero");
    // range copy and loop enable come from the same register value at the same edge
    a_range_zero_off: assert property ($past(aresetn) && vco_range_factor == 8'h00 |-> !vco_clock_enable)
        else $error("loop enabled with zero range");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered next cycle");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid)
        else $error("write not answered");
    a_read_rearm: assert property (rvalid && rready |=> arready && !rvalid)
        else $error("read channel not released");

endmodule : plc_properties

bind plc_top plc_properties plc_properties_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .rready, .stop_request, .osc_enable, .vco_clock_enable, .feedback_divider,
    .vco_range_factor, .crystal_clock_out, .base_clock_out, .clock_gen_irq);

// file: bench/plc_top_bench.sv
// self-checking bench of the loop control block: reset values, protection, track, lock flag, stop
// assumes: plc_top with the property checker bound to it
`timescale 1ns/1ps

module plc_top_bench;
    import plc_pkg::*;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000, feedback_divider;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [7:0]  vco_range_factor;
    logic [1:0]  bresp, rresp, r, vco_power_range;
    logic [2:0]  div_cnt = 3'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        lock_detect = 1'b0, track_detect = 1'b0, crystal_clock = 1'b0, vco_clock = 1'b0;
    logic        stop_request = 1'b0, break_active = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, osc_enable, vco_clock_enable, loop_track_mode;
    logic        crystal_clock_out, base_clock_out, clock_gen_irq, b;
    int          error_cnt = 0, num_checks = 0;

    plc_top plc_top_i (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .lock_detect, .track_detect, .crystal_clock, .vco_clock, .stop_request, .break_active,
        .osc_enable, .vco_clock_enable, .loop_track_mode, .feedback_divider, .vco_range_factor,
        .vco_power_range, .crystal_clock_out, .base_clock_out, .clock_gen_irq);

    // bus clock and slow source clocks
    always #2.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        div_cnt <= div_cnt + 3'h1;
        crystal_clock <= div_cnt[1];
        vco_clock <= div_cnt[2];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare, count, report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk); // idle edge: the next call never raises bready in this step
    endtask : wr

    // one read, data and response returned
    task automatic rd(input logic [7:0] idx);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk); // idle edge: the next call never raises rready in this step
    endtask : rd

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        rd(idx);
        check(d, exp);
    endtask : rchk

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        rchk(PLC_IDX_LOOP_CTRL, 32'h20);
        rchk(PLC_IDX_BW_MODE, 32'h00);
        rchk(PLC_IDX_MUL_LOW, 32'h40);
        rchk(PLC_IDX_MUL_HIGH, 32'h00);
        check(32'(feedback_divider), 32'h040);
        rchk(PLC_IDX_VCO_RANGE, 32'h40);
        check(32'(vco_range_factor), 32'h40);
        check(32'(vco_power_range), 32'h0);
        rd(8'h3b);
        check(32'(r), 32'(PLC_RESP_SLVERR));
        wr(8'h3b, 8'h00);
        check(32'(r), 32'(PLC_RESP_SLVERR));
        $display("reset values done");
    endtask : test_reset

    task automatic test_protect();
        wr(PLC_IDX_MUL_LOW, 8'h00);
        wr(PLC_IDX_VCO_RANGE, 8'h00);
        rchk(PLC_IDX_MUL_LOW, 32'h40);
        rchk(PLC_IDX_VCO_RANGE, 32'h40);
        wr(PLC_IDX_LOOP_CTRL, 8'h00);
        wr(PLC_IDX_MUL_LOW, 8'h00);
        rchk(PLC_IDX_MUL_LOW, 32'h00);
        check(32'(feedback_divider), 32'h001);
        wr(PLC_IDX_MUL_HIGH, 8'hff);
        rchk(PLC_IDX_MUL_HIGH, 32'h0f);
        check(32'(feedback_divider), 32'hf00);
        wr(PLC_IDX_VCO_RANGE, 8'h00);
        wr(PLC_IDX_LOOP_CTRL, 8'h20);
        wr(PLC_IDX_LOOP_CTRL, 8'h30);
        rchk(PLC_IDX_LOOP_CTRL, 32'h20);
        check(32'(vco_clock_enable), 32'h0);
        wr(PLC_IDX_LOOP_CTRL, 8'h00);
        wr(PLC_IDX_VCO_RANGE, 8'h40);
        wr(PLC_IDX_LOOP_CTRL, 8'h20);
        wr(PLC_IDX_LOOP_CTRL, 8'h30);
        rchk(PLC_IDX_LOOP_CTRL, 32'h30);
        wr(PLC_IDX_LOOP_CTRL, 8'h20);
        $display("write protection done");
    endtask : test_protect

    task automatic test_track();
        wr(PLC_IDX_BW_MODE, 8'h20);
        rchk(PLC_IDX_BW_MODE, 32'h20);
        check(32'(loop_track_mode), 32'h1);
        // entering auto keeps the manual track value 1; auto reads the hardware state
        wr(PLC_IDX_BW_MODE, 8'ha0);
        rchk(PLC_IDX_BW_MODE, 32'h80);
        track_detect <= 1'b1;
        repeat (10) @(posedge aclk);
        rchk(PLC_IDX_BW_MODE, 32'ha0);
        check(32'(loop_track_mode), 32'h1);
        track_detect <= 1'b0;
        wr(PLC_IDX_BW_MODE, 8'h00);
        rchk(PLC_IDX_BW_MODE, 32'h20);
        wr(PLC_IDX_BW_MODE, 8'h00);
        rchk(PLC_IDX_BW_MODE, 32'h00);
        $display("track select done");
    endtask : test_track

    task automatic test_lock();
        wr(PLC_IDX_BW_MODE, 8'h80);
        wr(PLC_IDX_LOOP_CTRL, 8'ha0);
        lock_detect <= 1'b1;
        repeat (12) @(posedge aclk);
        check(32'(clock_gen_irq), 32'h1);
        rchk(PLC_IDX_BW_MODE, 32'hc0);
        rchk(PLC_IDX_LOOP_CTRL, 32'he0);
        rchk(PLC_IDX_LOOP_CTRL, 32'ha0);
        check(32'(clock_gen_irq), 32'h0);
        wr(PLC_IDX_SYS_CTRL, 8'h00);
        break_active <= 1'b1;
        lock_detect <= 1'b0;
        repeat (12) @(posedge aclk);
        rchk(PLC_IDX_LOOP_CTRL, 32'he0);
        rchk(PLC_IDX_LOOP_CTRL, 32'he0);
        wr(PLC_IDX_SYS_CTRL, 8'h02);
        rchk(PLC_IDX_LOOP_CTRL, 32'he0);
        break_active <= 1'b0;
        rchk(PLC_IDX_LOOP_CTRL, 32'ha0);
        wr(PLC_IDX_BW_MODE, 8'h00);
        lock_detect <= 1'b1;
        repeat (12) @(posedge aclk);
        rchk(PLC_IDX_BW_MODE, 32'h00);
        rchk(PLC_IDX_LOOP_CTRL, 32'h20);
        check(32'(clock_gen_irq), 32'h0);
        $display("lock flag done");
    endtask : test_lock

    task automatic test_stop();
        stop_request <= 1'b1;
        repeat (4) @(posedge aclk);
        check({osc_enable, crystal_clock_out, base_clock_out, vco_clock_enable}, 32'h0);
        wr(PLC_IDX_SYS_CTRL, 8'h01);
        repeat (3) @(posedge aclk);
        check({osc_enable, vco_clock_enable}, 32'h2);
        // crystal source toggles every two bus cycles, so its gated copy must too
        b = crystal_clock_out;
        repeat (2) @(posedge aclk);
        check(32'(crystal_clock_out), 32'(!b));
        stop_request <= 1'b0;
        repeat (3) @(posedge aclk);
        check({osc_enable, vco_clock_enable}, 32'h3);
        // base clock is the crystal source halved: one toggle every four bus cycles
        b = base_clock_out;
        repeat (4) @(posedge aclk);
        check(32'(base_clock_out), 32'(!b));
        $display("stop modes done");
    endtask : test_stop

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // main sequence
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_protect();
        test_track();
        test_lock();
        test_stop();
        complete_run();
    end

    // watchdog, far beyond the expected run
    initial
    begin
        #40000;
        error_cnt++;
        complete_run();
    end

endmodule : plc_top_bench
